// ==== inc/usb_evt_regs.vh ====
// register map, fields and timing of the usb event block
// assumes a 10 mhz clock and a word-wide register port
`ifndef USB_EVT_REGS_VH
`define USB_EVT_REGS_VH
// timing
`define CLK_NS 100
`define IDLE_NS 3000000
`define SOF_NS 1003580
`define ERR_TRIES 2'h3
// register offsets
`define OFS_POWER 8'h00
`define OFS_IRQEN 8'h04
`define OFS_FRAME 8'h08
`define OFS_FADDR 8'h0C
`define OFS_INDEX 8'h10
`define OFS_RXCSR 8'h14
`define OFS_RQCNT 8'h18
`define OFS_RXADR 8'h1C
`define OFS_TXADR 8'h20
`define OFS_NAKLIM 8'h24
`define OFS_EPIEN 8'h28
// power_control_reg fields
`define PW_SUSP 0
`define PW_RESUME 1
`define PW_ATTACH 6
`define PW_HOST 7
// interrupt enable fields
`define IE_SUSP 0
`define IE_RES 1
`define IE_SOF 2
`define IE_RST 3
`define IE_SESS 4
// rx_ctrl_status fields
`define CS_RDY 0
`define CS_REQ 1
`define CS_STALL 2
`define CS_ERR 3
`define CS_ACL 4
`define CS_ARQ 5
// reset values
`define RST_IRQEN 5'h00
`define RST_EPIEN 4'h0
`define ALL_EPIEN 4'hF
`endif

// ==== design/usb_bus_events.v ====
// device bus events and host in sequencing
// assumes a serial engine that decodes tokens, reports handshakes, drives bits
//
// Summary of operation
// - 3 ms bus idle: transceiver suspended, suspend irq if enabled
// - resume while suspended: leave suspend, resume irq if enabled
// - resume bit: exit suspend, drive k state while set and attached
// - each sof stores its 11-bit frame number, pulses sof irq
// - no sof for 1.0035 ms: frame kept, pulse regenerated, resync
// - bus reset clears address, index, csr, flushes fifos, enables ep irqs
// - attach drives lines; only a bus reset answered at first
// - attach clear (reset default): both data lines tristated
// - no interrupt on connect; session end raises one
// - host in transactions use each endpoint's receive registers
// - control plus three in contexts, each with own target address
// - control context: endpoint 0 only, first fifo bytes
// - request sends in token; stored packet sets ready, ep irq
// - auto-clear drops ready after a max-sized unload
// - ready clear sends ack; auto-request sets request again
// - count decrements per request; 0 clears auto-request
// - count zero: short packet clears auto-request
// - naks retried until a nonzero nak limit is reached
// - stall not retried; stall flag and ep irq raised
// - errors retried; third clears request, sets error
`timescale 1ns/1ps
`default_nettype none
`include "usb_evt_regs.vh"
module usb_bus_events #(
    parameter IDLE_CYC = `IDLE_NS / `CLK_NS,
    parameter SOF_CYC = `SOF_NS / `CLK_NS
) (
    input wire clk,
    input wire reset,
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    input wire line_active,
    input wire resume_seen,
    input wire bus_reset_seen,
    input wire sof_valid,
    input wire [10:0] sof_frame,
    input wire session_end,
    input wire tx_dp,
    input wire tx_dm,
    input wire tx_drive,
    output wire xcvr_suspend,
    output wire dp_out,
    output wire dp_oe,
    output wire dm_out,
    output wire dm_oe,
    output wire respond_en,
    output reg fifo_flush,
    output reg irq_suspend,
    output reg irq_resume,
    output reg irq_sof,
    output reg irq_reset,
    output reg irq_session,
    output reg frame_pulse,
    output reg in_token,
    output reg [1:0] token_ep,
    output reg [6:0] token_addr,
    output reg ep0_fifo_sel,
    input wire rsp_data,
    input wire rsp_short,
    input wire rsp_nak,
    input wire rsp_stall,
    input wire rsp_err,
    input wire unload_max,
    input wire [1:0] unload_ep,
    output reg send_ack,
    output reg [1:0] ack_ep,
    output reg [3:0] ep_irq
);

// ----------------------------------------
// state and storage
// ----------------------------------------
localparam S_IDLE = 1'b0;
localparam S_WAIT = 1'b1;

reg susp_r, resume_r, attach_r, host_r, armed_r;
reg [4:0] irqen_r;
reg [10:0] frame_r;
reg [6:0] faddr_r;
reg [1:0] index_r;
reg [3:0] epien_r;
reg [31:0] idle_cnt_r;
reg [31:0] sof_cnt_r;
reg sof_seen_r;
reg state_r;
reg [1:0] cur_r;
reg [1:0] rr_r;
// per receive context; index 0 is the control context
reg rdy_r [0:3];
reg req_r [0:3];
reg stall_r [0:3];
reg err_r [0:3];
reg acl_r [0:3];
reg arq_r [0:3];
reg [7:0] cnt_r [0:3];
reg [6:0] rxadr_r [0:3];
reg [6:0] txadr_r [0:3];
reg [7:0] naklim_r [0:3];
reg [7:0] nakn_r [0:3];
reg [1:0] errn_r [0:3];
reg [31:0] rd_nxt;
reg [2:0] pick_nxt;
integer i;

// round robin: a nakking endpoint never starves the others
function [2:0] pick;
    input [3:0] act;
    input [1:0] from;
    integer k;
    reg [1:0] j;
    begin
        pick = 3'h0;
        for (k = 3; k >= 0; k = k - 1) begin
            j = from + k[1:0];
            if (act[j]) begin
                pick = {1'b1, j};
            end
        end
    end
endfunction

function [31:0] csr_word;
    input [1:0] n;
    begin
        csr_word = 32'h0;
        csr_word[`CS_RDY] = rdy_r[n];
        csr_word[`CS_REQ] = req_r[n];
        csr_word[`CS_STALL] = stall_r[n];
        csr_word[`CS_ERR] = err_r[n];
        csr_word[`CS_ACL] = acl_r[n];
        csr_word[`CS_ARQ] = arq_r[n];
    end
endfunction

// ----------------------------------------
// transceiver and line drive
// ----------------------------------------
// resume is a k state: minus high, plus low
assign xcvr_suspend = susp_r;
assign dp_out = resume_r ? 1'b0 : tx_dp;
assign dm_out = resume_r ? 1'b1 : tx_dm;
assign dp_oe = attach_r & (resume_r | tx_drive);
assign dm_oe = attach_r & (resume_r | tx_drive);
assign respond_en = attach_r & armed_r;

// ----------------------------------------
// suspend, resume and sof tracking
// ----------------------------------------
// counters run on clk, so the limits hold only for the 10 mhz rate
always @(posedge clk) begin
    irq_suspend <= 1'b0;
    irq_resume <= 1'b0;
    irq_sof <= 1'b0;
    frame_pulse <= 1'b0;
    if (reset) begin
        susp_r <= 1'b0;
        idle_cnt_r <= 32'h0;
        sof_cnt_r <= 32'h0;
        sof_seen_r <= 1'b0;
        frame_r <= 11'h000;
    end else begin
        if (line_active || !attach_r || host_r) begin
            idle_cnt_r <= 32'h0;
        end else if (!susp_r) begin
            if (idle_cnt_r == IDLE_CYC - 1) begin
                susp_r <= 1'b1;
                irq_suspend <= irqen_r[`IE_SUSP];
            end else begin
                idle_cnt_r <= idle_cnt_r + 32'h1;
            end
        end
        if (susp_r && resume_seen) begin
            susp_r <= 1'b0;
            idle_cnt_r <= 32'h0;
            irq_resume <= irqen_r[`IE_RES];
        end else if (susp_r && resume_r) begin
            susp_r <= 1'b0;
            idle_cnt_r <= 32'h0;
        end
        if (sof_valid && !host_r) begin
            frame_r <= sof_frame;
            irq_sof <= irqen_r[`IE_SOF];
            frame_pulse <= 1'b1;
            sof_seen_r <= 1'b1;
            sof_cnt_r <= 32'h0;
        end else if (sof_seen_r) begin
            if (sof_cnt_r == SOF_CYC - 1) begin
                frame_pulse <= 1'b1;
                sof_cnt_r <= 32'h0;
            end else begin
                sof_cnt_r <= sof_cnt_r + 32'h1;
            end
        end
    end
end

// ----------------------------------------
// register read port
// ----------------------------------------
always @* begin
    rd_nxt = 32'h0;
    case (reg_addr)
        `OFS_POWER: begin
            rd_nxt[`PW_SUSP] = susp_r;
            rd_nxt[`PW_RESUME] = resume_r;
            rd_nxt[`PW_ATTACH] = attach_r;
            rd_nxt[`PW_HOST] = host_r;
        end
        `OFS_IRQEN: rd_nxt[4:0] = irqen_r;
        `OFS_FRAME: rd_nxt[10:0] = frame_r;
        `OFS_FADDR: rd_nxt[6:0] = faddr_r;
        `OFS_INDEX: rd_nxt[1:0] = index_r;
        `OFS_RXCSR: rd_nxt = csr_word(index_r);
        `OFS_RQCNT: rd_nxt[7:0] = cnt_r[index_r];
        `OFS_RXADR: rd_nxt[6:0] = rxadr_r[index_r];
        `OFS_TXADR: rd_nxt[6:0] = txadr_r[index_r];
        `OFS_NAKLIM: rd_nxt[7:0] = naklim_r[index_r];
        `OFS_EPIEN: rd_nxt[3:0] = epien_r;
        default: rd_nxt = 32'h0;
    endcase
end

// unmapped reads zero; data only in the cycle after the strobe
always @(posedge clk) begin
    if (reset) begin
        reg_rdata <= 32'h0;
    end else begin
        reg_rdata <= reg_rd ? rd_nxt : 32'h0;
    end
end

always @* begin
    pick_nxt = pick({req_r[3] & ~rdy_r[3] & ~stall_r[3], req_r[2] & ~rdy_r[2] & ~stall_r[2],
        req_r[1] & ~rdy_r[1] & ~stall_r[1], req_r[0] & ~rdy_r[0] & ~stall_r[0]}, rr_r);
end

// ----------------------------------------
// control registers and host in sequencer
// ----------------------------------------
// software writes first, so a same-cycle hardware set wins
always @(posedge clk) begin
    irq_reset <= 1'b0;
    irq_session <= 1'b0;
    fifo_flush <= 1'b0;
    in_token <= 1'b0;
    send_ack <= 1'b0;
    ep_irq <= 4'h0;
    if (reset) begin
        resume_r <= 1'b0;
        attach_r <= 1'b0;
        host_r <= 1'b0;
        armed_r <= 1'b0;
        irqen_r <= `RST_IRQEN;
        faddr_r <= 7'h00;
        index_r <= 2'h0;
        epien_r <= `RST_EPIEN;
        state_r <= S_IDLE;
        cur_r <= 2'h0;
        rr_r <= 2'h0;
        token_ep <= 2'h0;
        token_addr <= 7'h00;
        ep0_fifo_sel <= 1'b0;
        ack_ep <= 2'h0;
        for (i = 0; i < 4; i = i + 1) begin
            rdy_r[i] <= 1'b0;
            req_r[i] <= 1'b0;
            stall_r[i] <= 1'b0;
            err_r[i] <= 1'b0;
            acl_r[i] <= 1'b0;
            arq_r[i] <= 1'b0;
            cnt_r[i] <= 8'h00;
            rxadr_r[i] <= 7'h00;
            txadr_r[i] <= 7'h00;
            naklim_r[i] <= 8'h00;
            nakn_r[i] <= 8'h00;
            errn_r[i] <= 2'h0;
        end
    end else begin
        if (reg_wr) begin
            case (reg_addr)
                `OFS_POWER: begin
                    resume_r <= reg_wdata[`PW_RESUME];
                    attach_r <= reg_wdata[`PW_ATTACH];
                    host_r <= reg_wdata[`PW_HOST];
                    if (!reg_wdata[`PW_ATTACH]) begin
                        armed_r <= 1'b0;
                    end
                end
                `OFS_IRQEN: irqen_r <= reg_wdata[4:0];
                `OFS_FADDR: faddr_r <= reg_wdata[6:0];
                `OFS_INDEX: index_r <= reg_wdata[1:0];
                `OFS_RXCSR: begin
                    // ready, stall, error: write zero clears, software never sets
                    if (rdy_r[index_r] && !reg_wdata[`CS_RDY]) begin
                        rdy_r[index_r] <= 1'b0;
                        send_ack <= 1'b1;
                        ack_ep <= index_r;
                        if (arq_r[index_r]) begin
                            req_r[index_r] <= 1'b1;
                        end
                    end
                    if (reg_wdata[`CS_REQ]) begin
                        req_r[index_r] <= 1'b1;
                        nakn_r[index_r] <= 8'h00;
                        errn_r[index_r] <= 2'h0;
                    end
                    if (!reg_wdata[`CS_STALL]) begin
                        stall_r[index_r] <= 1'b0;
                    end
                    if (!reg_wdata[`CS_ERR]) begin
                        err_r[index_r] <= 1'b0;
                    end
                    acl_r[index_r] <= reg_wdata[`CS_ACL];
                    arq_r[index_r] <= reg_wdata[`CS_ARQ];
                end
                `OFS_RQCNT: cnt_r[index_r] <= reg_wdata[7:0];
                `OFS_RXADR: rxadr_r[index_r] <= reg_wdata[6:0];
                `OFS_TXADR: txadr_r[index_r] <= reg_wdata[6:0];
                `OFS_NAKLIM: naklim_r[index_r] <= reg_wdata[7:0];
                `OFS_EPIEN: epien_r <= reg_wdata[3:0];
                default: ;
            endcase
        end
        // auto-clear on max-sized unload, same ack path
        if (unload_max && acl_r[unload_ep] && rdy_r[unload_ep]) begin
            rdy_r[unload_ep] <= 1'b0;
            send_ack <= 1'b1;
            ack_ep <= unload_ep;
            if (arq_r[unload_ep]) begin
                req_r[unload_ep] <= 1'b1;
            end
        end
        if (session_end) begin
            irq_session <= irqen_r[`IE_SESS];
        end
        case (state_r)
            S_IDLE: begin
                if (host_r && pick_nxt[2]) begin
                    cur_r <= pick_nxt[1:0];
                    in_token <= 1'b1;
                    token_ep <= pick_nxt[1:0];
                    token_addr <= rxadr_r[pick_nxt[1:0]];
                    ep0_fifo_sel <= (pick_nxt[1:0] == 2'h0);
                    state_r <= S_WAIT;
                    // count only first attempts, not retries
                    if (nakn_r[pick_nxt[1:0]] == 8'h00 && errn_r[pick_nxt[1:0]] == 2'h0
                        && cnt_r[pick_nxt[1:0]] != 8'h00) begin
                        cnt_r[pick_nxt[1:0]] <= cnt_r[pick_nxt[1:0]] - 8'h01;
                        if (cnt_r[pick_nxt[1:0]] == 8'h01) begin
                            arq_r[pick_nxt[1:0]] <= 1'b0;
                        end
                    end
                end
            end
            S_WAIT: begin
                if (rsp_data) begin
                    rdy_r[cur_r] <= 1'b1;
                    req_r[cur_r] <= 1'b0;
                    ep_irq[cur_r] <= epien_r[cur_r];
                    nakn_r[cur_r] <= 8'h00;
                    errn_r[cur_r] <= 2'h0;
                    if (rsp_short && cnt_r[cur_r] == 8'h00) begin
                        arq_r[cur_r] <= 1'b0;
                    end
                    state_r <= S_IDLE;
                end else if (rsp_nak) begin
                    nakn_r[cur_r] <= nakn_r[cur_r] + 8'h01;
                    if (naklim_r[cur_r] != 8'h00
                        && nakn_r[cur_r] + 8'h01 == naklim_r[cur_r]) begin
                        req_r[cur_r] <= 1'b0;
                        err_r[cur_r] <= 1'b1;
                        ep_irq[cur_r] <= epien_r[cur_r];
                    end
                    rr_r <= cur_r + 2'h1;
                    state_r <= S_IDLE;
                end else if (rsp_stall) begin
                    stall_r[cur_r] <= 1'b1;
                    req_r[cur_r] <= 1'b0;
                    ep_irq[cur_r] <= epien_r[cur_r];
                    state_r <= S_IDLE;
                end else if (rsp_err) begin
                    errn_r[cur_r] <= errn_r[cur_r] + 2'h1;
                    if (errn_r[cur_r] + 2'h1 == `ERR_TRIES) begin
                        req_r[cur_r] <= 1'b0;
                        err_r[cur_r] <= 1'b1;
                        ep_irq[cur_r] <= epien_r[cur_r];
                        errn_r[cur_r] <= 2'h0;
                    end
                    rr_r <= cur_r + 2'h1;
                    state_r <= S_IDLE;
                end
            end
            default: state_r <= S_IDLE;
        endcase
        // bus reset outranks all in device mode
        if (bus_reset_seen && !host_r) begin
            faddr_r <= 7'h00;
            index_r <= 2'h0;
            fifo_flush <= 1'b1;
            epien_r <= `ALL_EPIEN;
            irq_reset <= irqen_r[`IE_RST];
            armed_r <= attach_r;
            send_ack <= 1'b0;
            for (i = 0; i < 4; i = i + 1) begin
                rdy_r[i] <= 1'b0;
                req_r[i] <= 1'b0;
                stall_r[i] <= 1'b0;
                err_r[i] <= 1'b0;
                acl_r[i] <= 1'b0;
                arq_r[i] <= 1'b0;
            end
        end
    end
end

endmodule
`default_nettype wire

// ==== dv/usb_engine_model.sv ====
// far-side engine model: one handshake pulse per in token
// assumes one token outstanding; mode and lat set by the bench
`timescale 1ns/1ps
`default_nettype none
module usb_engine_model (
    input wire logic clk,
    input wire logic reset,
    input wire logic in_token,
    input wire logic [2:0] mode,
    input wire logic [3:0] lat,
    output logic rsp_data,
    output logic rsp_short,
    output logic rsp_nak,
    output logic rsp_stall,
    output logic rsp_err
);
    logic [4:0] cnt_r;
    // --------------------------------
    // answer
    // --------------------------------
    // lat plus one idle cycles, then one pulse
    always @(posedge clk) begin
        {rsp_data, rsp_short, rsp_nak, rsp_stall, rsp_err} <= 5'h00;
        if (reset) begin
            cnt_r <= 5'h00;
        end else if (in_token) begin
            cnt_r <= {1'b0, lat} + 5'h01;
        end else if (cnt_r != 5'h00) begin
            cnt_r <= cnt_r - 5'h01;
            if (cnt_r == 5'h01) begin
                case (mode)
                    3'h0: rsp_data <= 1'b1;
                    3'h1: {rsp_data, rsp_short} <= 2'h3;
                    3'h2: rsp_nak <= 1'b1;
                    3'h3: rsp_stall <= 1'b1;
                    default: rsp_err <= 1'b1;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// ==== dv/usb_evt_asserts.sv ====
// checker for usb_bus_events ports
// assumes binding into the design; shadows power and irq enable writes
`timescale 1ns/1ps
`default_nettype none
`include "usb_evt_regs.vh"
module usb_evt_asserts #(
    parameter IDLE_CYC = 20,
    parameter SOF_CYC = 15
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic line_active,
    input wire logic resume_seen,
    input wire logic bus_reset_seen,
    input wire logic sof_valid,
    input wire logic session_end,
    input wire logic tx_drive,
    input wire logic rsp_stall,
    input wire logic xcvr_suspend,
    input wire logic dp_out,
    input wire logic dp_oe,
    input wire logic dm_out,
    input wire logic dm_oe,
    input wire logic fifo_flush,
    input wire logic irq_reset,
    input wire logic irq_session,
    input wire logic frame_pulse,
    input wire logic in_token
);
    localparam int SOF_WIN = SOF_CYC + 2;
    logic att_r, res_r, host_r;
    logic [4:0] ien_r;
    logic [15:0] idle_r;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // --------------------------------
    // shadows
    // --------------------------------
    // idle count saturates so it never wraps under the limit
    always @(posedge clk) begin
        if (reset) begin
            {att_r, res_r, host_r} <= 3'h0;
            ien_r <= 5'h00;
        end else begin
            if (reg_wr && reg_addr == `OFS_POWER) begin
                att_r <= reg_wdata[`PW_ATTACH];
                res_r <= reg_wdata[`PW_RESUME];
                host_r <= reg_wdata[`PW_HOST];
            end
            if (reg_wr && reg_addr == `OFS_IRQEN) begin
                ien_r <= reg_wdata[4:0];
            end
        end
        if (reset || line_active || !att_r || host_r) begin
            idle_r <= 16'h0000;
        end else if (idle_r != 16'hFFFF) begin
            idle_r <= idle_r + 16'h0001;
        end
    end
    // --------------------------------
    // properties
    // --------------------------------
    AST_SUSP_EARLY: assert property (
        $rose(xcvr_suspend) |-> idle_r >= IDLE_CYC - 2) else $error("early suspend");
    AST_SUSP_LATE: assert property (
        idle_r == IDLE_CYC + 2 && !res_r |-> xcvr_suspend) else $error("suspend missing");
    AST_RESUME_EXIT: assert property (
        xcvr_suspend && resume_seen |=> !xcvr_suspend) else $error("resume ignored");
    AST_RESUME_K: assert property (
        att_r && res_r |-> dp_oe && dm_oe && !dp_out && dm_out) else $error("no k state");
    AST_DETACHED: assert property (
        !att_r |-> !dp_oe && !dm_oe) else $error("drive while detached");
    AST_ATTACH_DRIVE: assert property (
        att_r && tx_drive |-> dp_oe && dm_oe) else $error("lines not driven");
    AST_BUS_RESET: assert property (
        bus_reset_seen && att_r && !host_r |=> fifo_flush && irq_reset == ien_r[`IE_RST])
        else $error("bus reset missed");
    AST_SOF_TRACK: assert property (
        sof_valid && !host_r |=> frame_pulse ##[1:SOF_WIN] frame_pulse)
        else $error("frame pulse missing");
    AST_SESSION: assert property (
        session_end && ien_r[`IE_SESS] |=> irq_session) else $error("no session irq");
    AST_STALL_ONCE: assert property (
        rsp_stall |=> !in_token [*8]) else $error("stall retried");
    cover property ($rose(xcvr_suspend));
    cover property (frame_pulse && !$past(sof_valid));
    cover property (rsp_stall);
endmodule
bind usb_bus_events usb_evt_asserts #(.IDLE_CYC(IDLE_CYC), .SOF_CYC(SOF_CYC)) i_usb_evt_asserts (
    .clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .line_active, .resume_seen,
    .bus_reset_seen, .sof_valid, .session_end, .tx_drive, .rsp_stall, .xcvr_suspend,
    .dp_out, .dp_oe, .dm_out, .dm_oe, .fifo_flush, .irq_reset, .irq_session,
    .frame_pulse, .in_token
);
`default_nettype wire

// ==== dv/usb_bus_events_bench.sv ====
// self-checking bench for usb_bus_events
// assumes the engine model answers tokens
`timescale 1ns/1ps
`default_nettype none
`include "usb_evt_regs.vh"
module usb_bus_events_bench;
    localparam int IC = 20;
    localparam int SC = 15;
    logic clk, reset, reg_wr, reg_rd, line_active, tx_dp, tx_dm, tx_drive, pend;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, f, a, e, m;
    logic [10:0] sof_frame;
    logic [4:0] ev;
    logic [1:0] unload_ep, token_ep, ack_ep;
    logic [6:0] token_addr;
    logic [3:0] ep_irq, lat;
    logic [2:0] mode;
    logic xcvr_suspend, dp_out, dp_oe, dm_out, dm_oe, respond_en, fifo_flush, irq_suspend;
    logic irq_resume, irq_sof, irq_reset, irq_session, frame_pulse, in_token, ep0_fifo_sel;
    logic send_ack, rsp_data, rsp_short, rsp_nak, rsp_stall, rsp_err;
    logic [31:0] eq[$], mq[$];
    int n[8], err_total, checks, t, k, j;
    usb_bus_events #(.IDLE_CYC(IC), .SOF_CYC(SC)) i_usb_bus_events (
        .clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .line_active,
        .resume_seen(ev[0]), .bus_reset_seen(ev[1]), .sof_valid(ev[2]), .sof_frame,
        .session_end(ev[3]), .tx_dp, .tx_dm, .tx_drive, .xcvr_suspend, .dp_out, .dp_oe,
        .dm_out, .dm_oe, .respond_en, .fifo_flush, .irq_suspend, .irq_resume, .irq_sof,
        .irq_reset, .irq_session, .frame_pulse, .in_token, .token_ep, .token_addr,
        .ep0_fifo_sel, .rsp_data, .rsp_short, .rsp_nak, .rsp_stall, .rsp_err,
        .unload_max(ev[4]), .unload_ep, .send_ack, .ack_ep, .ep_irq
    );
    usb_engine_model i_usb_engine_model (
        .clk, .reset, .in_token, .mode, .lat, .rsp_data, .rsp_short, .rsp_nak, .rsp_stall,
        .rsp_err
    );
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // --------------------------------
    // helpers
    // --------------------------------
    task chk(input logic [31:0] g, input logic [31:0] x);
        checks++;
        if (g !== x) begin
            err_total++;
            $display("[FAIL] %0t got %h exp %h", $time, g, x);
        end
    endtask
    task wr(input logic [7:0] ad, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= ad;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // expectation queued; monitor compares in the answer cycle
    task rd(input logic [7:0] ad, input logic [31:0] x, input logic [31:0] mk);
        @(posedge clk);
        reg_addr <= ad;
        reg_rd <= 1'b1;
        eq.push_back(x);
        mq.push_back(mk);
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask
    // one-cycle event, one more edge for registered answers
    task pl(input int i);
        ev[i] <= 1'b1;
        @(posedge clk);
        ev[i] <= 1'b0;
        @(posedge clk);
    endtask
    task wc(input int i, input int v);
        int w;
        for (w = 0; w < 400 && n[i] < v; w++) @(posedge clk);
        if (n[i] < v) chk(n[i], v);
    endtask
    task done(input string s);
        $display("test %0s ends", s);
    endtask
    task finish_test();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // read answers and pulse counters
    always @(posedge clk) begin
        if (pend === 1'b1 && eq.size() > 0) begin
            e = eq.pop_front();
            m = mq.pop_front();
            chk(reg_rdata & m, e & m);
        end
        pend <= reg_rd;
        n[0] += (in_token === 1'b1);
        n[1] += (send_ack === 1'b1);
        n[6] += (irq_suspend === 1'b1);
        n[7] += (irq_resume === 1'b1);
        for (j = 0; j < 4; j++) n[2 + j] += (ep_irq[j] === 1'b1);
    end
    initial begin
        #(20000 * 100);
        err_total++;
        finish_test();
    end
    // --------------------------------
    // tests
    // --------------------------------
    initial begin
        {reg_wr, reg_rd, ev, tx_dp, tx_dm, tx_drive, reg_addr, reg_wdata} = '0;
        {sof_frame, unload_ep, mode, lat} = '0;
        reset = 1'b1;
        line_active = 1'b1;
        void'($urandom(3));
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        tx_dp <= $urandom;
        tx_dm <= $urandom;
        tx_drive <= 1'b1;
        rd(`OFS_POWER, 32'h0, 32'hFF);
        rd(`OFS_EPIEN, `RST_EPIEN, 32'hF);
        chk({dp_oe, dm_oe, dp_out, dm_out}, {2'h0, tx_dp, tx_dm});
        wr(`OFS_IRQEN, 32'h1F);
        wr(`OFS_POWER, 32'h40);
        @(posedge clk);
        chk({dp_oe, dm_oe, respond_en, irq_session}, 4'hC);
        done("attach");
        wr(`OFS_FADDR, $urandom);
        wr(`OFS_INDEX, 32'h2);
        wr(`OFS_RXCSR, 32'h30);
        pl(1);
        chk(respond_en, 1'b1);
        rd(`OFS_FADDR, 32'h0, 32'h7F);
        rd(`OFS_INDEX, 32'h0, 32'h3);
        rd(`OFS_EPIEN, `ALL_EPIEN, 32'hF);
        wr(`OFS_INDEX, 32'h2);
        rd(`OFS_RXCSR, 32'h0, 32'h3F);
        done("bus reset");
        f = $urandom & 32'h7FF;
        sof_frame <= f[10:0];
        pl(2);
        chk(irq_sof, 1'b1);
        rd(`OFS_FRAME, f, 32'h7FF);
        sof_frame <= ~f[10:0];
        repeat (3 * SC) @(posedge clk);
        rd(`OFS_FRAME, f, 32'h7FF);
        pl(2);
        rd(`OFS_FRAME, ~f, 32'h7FF);
        done("sof");
        line_active <= 1'b0;
        repeat (IC + 6) @(posedge clk);
        chk(n[6], 1);
        rd(`OFS_POWER, 32'h41, 32'hFF);
        line_active <= 1'b1;
        pl(0);
        chk(xcvr_suspend, 1'b0);
        line_active <= 1'b0;
        repeat (IC + 6) @(posedge clk);
        chk(n[7], 1);
        chk(xcvr_suspend, 1'b1);
        wr(`OFS_POWER, 32'h42);
        repeat (2) @(posedge clk);
        chk({xcvr_suspend, dp_oe, dm_oe, dp_out, dm_out}, 5'h0D);
        line_active <= 1'b1;
        repeat (10) @(posedge clk);
        wr(`OFS_POWER, 32'h40);
        pl(3);
        chk(irq_session, 1'b1);
        done("suspend");
        wr(`OFS_POWER, 32'hC0);
        for (k = 0; k < 4; k++) begin
            a = $urandom & 32'h7F;
            lat <= $urandom;
            wr(`OFS_INDEX, k);
            wr(`OFS_RXADR, a);
            wr(`OFS_RXCSR, 32'h02);
            wc(2 + k, n[2 + k] + 1);
            chk({token_ep, token_addr, ep0_fifo_sel}, {k[1:0], a[6:0], k == 0});
            rd(`OFS_RXCSR, 32'h01, 32'h3F);
            t = n[1];
            wr(`OFS_RXCSR, 32'h00);
            wc(1, t + 1);
            chk(ack_ep, k[1:0]);
        end
        wr(`OFS_INDEX, 32'h1);
        wr(`OFS_RQCNT, 32'h2);
        wr(`OFS_RXCSR, 32'h32);
        wc(3, n[3] + 1);
        t = n[0];
        unload_ep <= 2'h1;
        pl(4);
        wc(3, n[3] + 1);
        rd(`OFS_RQCNT, 32'h0, 32'hFF);
        rd(`OFS_RXCSR, 32'h11, 32'h3F);
        pl(4);
        repeat (40) @(posedge clk);
        chk(n[0] - t, 1);
        rd(`OFS_RXCSR, 32'h10, 32'h3F);
        wr(`OFS_INDEX, 32'h2);
        wr(`OFS_RQCNT, 32'h0);
        wr(`OFS_RXCSR, 32'h22);
        wc(4, n[4] + 1);
        rd(`OFS_RXCSR, 32'h21, 32'h3F);
        mode <= 3'h1;
        wr(`OFS_RXCSR, 32'h20);
        wc(4, n[4] + 1);
        rd(`OFS_RXCSR, 32'h01, 32'h3F);
        done("host in");
        wr(`OFS_INDEX, 32'h3);
        mode <= 3'h2;
        t = n[0];
        wr(`OFS_RXCSR, 32'h02);
        wc(0, t + 6);
        mode <= 3'h0;
        wc(5, n[5] + 1);
        rd(`OFS_RXCSR, 32'h01, 32'h3F);
        for (k = 2; k < 5; k++) begin
            wr(`OFS_RXCSR, 32'h00);
            wr(`OFS_NAKLIM, 32'h3);
            mode <= k[2:0];
            t = n[0];
            wr(`OFS_RXCSR, 32'h02);
            wc(5, n[5] + 1);
            rd(`OFS_RXCSR, k == 3 ? 32'h04 : 32'h08, 32'h3F);
            if (k == 4) chk(n[0] - t, 3);
        end
        done("host retries");
        finish_test();
    end
endmodule
`default_nettype wire
